// >>> sevt_pkg.sv
// package of offsets, field positions and reset values for the event-time/id/process-ram bank
// assumes byte-wide register ports with 16-bit byte addresses
package sevt_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int          ADDR_W              = 16;
  localparam logic [15:0] NET_CHANGE_TIME_OFS = 16'h09f0;
  localparam logic [15:0] LOC_START_TIME_OFS  = 16'h09f8;
  localparam logic [15:0] LOC_CHANGE_TIME_OFS = 16'h09fc;
  localparam logic [15:0] PRODUCT_IDENTIFICATION_OFS      = 16'h0e00;
  localparam logic [15:0] VENDOR_IDENTIFICATION_OFS       = 16'h0e08;
  localparam logic [15:0] PARAM_RAM_BASE      = 16'h0580;
  localparam logic [15:0] PDRAM_BASE          = 16'h1000;
  localparam logic [15:0] PDRAM_LAST          = 16'h4fff;

  // ----------------------------------------------------------------
  // event time slots, selected by address bits 3:2 inside 0x09f0..0x09ff
  // ----------------------------------------------------------------
  localparam logic [1:0]  SLOT_NET_CHANGE     = 2'h0;
  localparam logic [1:0]  SLOT_LOC_START      = 2'h2;
  localparam logic [1:0]  SLOT_LOC_CHANGE     = 2'h3;
  localparam logic [31:0] EVT_TIME_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // vendor identification fields
  // ----------------------------------------------------------------
  localparam int          VENDOR_COMPANY_LSB  = 0;
  localparam int          VENDOR_COMPANY_W    = 24;
  localparam int          VENDOR_DEPT_LSB     = 24;
  localparam int          VENDOR_DEPT_W       = 8;
  localparam logic [3:0]  VENDOR_TEST_NIBBLE  = 4'he;

  // ----------------------------------------------------------------
  // port indices
  // ----------------------------------------------------------------
  localparam int          PORT_NET            = 0;
  localparam int          PORT_LOC            = 1;
  localparam int          NUM_PORTS           = 2;

endpackage

// >>> sevt_bank.sv
// register bank: event-time capture, identity words, parameter ram and process data ram
// assumes both access ports and the event/loader inputs are logic on clk, no synchronisers
//
// Operation
// [RULE1] network event time holds frame-start time of a frame raising a buffer event
// [RULE2] local start event time captures local time on a buffer start event
// [RULE3] local change event time captures on the same buffer start event
// [RULE4] reading low byte snapshots upper bits, per port, for consistent reads
// [RULE5] fixed 64-bit product identification readable from both ports
// [RULE6] vendor identification: company bits 23:0, department 31:24, test nibble E
// [RULE7] process data ram spans 0x1000 to 0x4fff, 16 kbytes, contents undefined
// [RULE8] process data ram accessible only while eeprom loaded correctly
// [RULE9] startup loader writes configuration bytes into parameter ram at 0x0580
// [RULE10] parameter ram also writable from both ports after startup
// [RULE11] blocked process ram reads return zero and writes are dropped
`timescale 1ns/1ns
`default_nettype none

module sevt_bank
  import sevt_pkg::*;
#(
  parameter logic [63:0] PRODUCT_IDENTIFICATION      = 64'h0000_0000_0000_0001, // arbitrary value
  parameter logic [23:0] COMPANY_CODE    = 24'h00_0001,             // arbitrary value
  parameter logic [7:0]  DEPT_CODE       = 8'h00,                   // arbitrary value
  parameter int          PDRAM_BYTES     = 16384,
  parameter int          PARAM_RAM_BYTES = 128
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // network side access
  input  wire logic [ADDR_W-1:0] net_addr,
  input  wire logic              net_rd,
  input  wire logic              net_wr,
  input  wire logic [7:0]        net_wdata,
  output logic      [7:0]        net_rdata,
  output logic                   net_rvalid,
  // local process data port access
  input  wire logic [ADDR_W-1:0] loc_addr,
  input  wire logic              loc_rd,
  input  wire logic              loc_wr,
  input  wire logic [7:0]        loc_wdata,
  output logic      [7:0]        loc_rdata,
  output logic                   loc_rvalid,
  // time base and buffer manager events
  input  wire logic [31:0]       local_time,
  input  wire logic              frame_start,
  input  wire logic              buffer_manager_net_event,
  input  wire logic              buffer_manager_loc_start,
  // eeprom loader and status
  input  wire logic              eeprom_loaded_ok,
  input  wire logic              load_wr,
  input  wire logic [15:0]       load_offset,
  input  wire logic [7:0]        load_data,
  // vendor code classification
  output logic                   vendor_is_test
);

  localparam int PD_AW = $clog2(PDRAM_BYTES);
  localparam int PR_AW = $clog2(PARAM_RAM_BYTES);
  localparam logic [63:0] VENDOR_IDENTIFICATION = {32'h0000_0000, DEPT_CODE, COMPANY_CODE}; // RULE6

  // a single byte would leave a zero-width ram index
  if (PDRAM_BYTES < 2 || PDRAM_BYTES > int'(PDRAM_LAST - PDRAM_BASE) + 1) begin : g_bad_pdram
    $error("PDRAM_BYTES does not fit the process ram window");
  end
  if (PARAM_RAM_BYTES < 2 || PARAM_RAM_BYTES > int'(16'h0a00 - PARAM_RAM_BASE)) begin : g_bad_pram
    $error("PARAM_RAM_BYTES out of range");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // port bundling
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_a   [NUM_PORTS];
  logic              rd_a     [NUM_PORTS];
  logic              wr_a     [NUM_PORTS];
  logic [7:0]        wdata_a  [NUM_PORTS];
  logic [7:0]        rdata_q  [NUM_PORTS];
  logic              rvalid_q [NUM_PORTS];
  logic              pd_hit   [NUM_PORTS];
  logic              pr_hit   [NUM_PORTS];

  assign addr_a[PORT_NET]  = net_addr;
  assign rd_a[PORT_NET]    = net_rd;
  assign wr_a[PORT_NET]    = net_wr;
  assign wdata_a[PORT_NET] = net_wdata;
  assign addr_a[PORT_LOC]  = loc_addr;
  assign rd_a[PORT_LOC]    = loc_rd;
  assign wr_a[PORT_LOC]    = loc_wr;
  assign wdata_a[PORT_LOC] = loc_wdata;
  assign net_rdata  = rdata_q[PORT_NET];
  assign net_rvalid = rvalid_q[PORT_NET];
  assign loc_rdata  = rdata_q[PORT_LOC];
  assign loc_rvalid = rvalid_q[PORT_LOC];

  assign vendor_is_test = (VENDOR_IDENTIFICATION[31:28] == VENDOR_TEST_NIBBLE); // RULE6

  // ----------------------------------------------------------------
  // event time capture
  // ----------------------------------------------------------------
  logic [31:0] frame_time_q;
  logic [31:0] frame_time_now;
  logic [31:0] evt_q [4];

  // an event raised in the frame-start cycle itself belongs to the new frame
  assign frame_time_now = frame_start ? local_time : frame_time_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_time_q <= EVT_TIME_RESET;
    end else if (frame_start) begin
      frame_time_q <= local_time;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q[0] <= EVT_TIME_RESET;
      evt_q[1] <= EVT_TIME_RESET;
      evt_q[2] <= EVT_TIME_RESET;
      evt_q[3] <= EVT_TIME_RESET;
    end else begin
      if (buffer_manager_net_event) begin
        evt_q[SLOT_NET_CHANGE] <= frame_time_now; // RULE1
      end
      if (buffer_manager_loc_start) begin
        evt_q[SLOT_LOC_START]  <= local_time;     // RULE2
        evt_q[SLOT_LOC_CHANGE] <= local_time;     // RULE3
      end
    end
  end

  // ----------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------
  logic [7:0] pdram [PDRAM_BYTES];
  logic [7:0] pram  [PARAM_RAM_BYTES];

  // no reset on the arrays: contents are undefined until written
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (wr_a[p] && pd_hit[p] && eeprom_loaded_ok) begin // RULE8 RULE11
        pdram[PD_AW'(addr_a[p] - PDRAM_BASE)] <= wdata_a[p]; // RULE7
      end
    end
  end

  // local port loop runs last, so it wins a same-byte clash; loader wins over both
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (wr_a[p] && pr_hit[p]) begin
        pram[PR_AW'(addr_a[p] - PARAM_RAM_BASE)] <= wdata_a[p]; // RULE10
      end
    end
    if (load_wr && load_offset < 16'(PARAM_RAM_BYTES)) begin
      pram[PR_AW'(load_offset)] <= load_data; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // per-port read path and upper-bit snapshots
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [23:0] hi_q [4];
    logic        evt_hit;
    logic [1:0]  slot;
    logic [7:0]  rd_byte;
    logic [63:0] id_word;

    assign slot    = addr_a[p][3:2];
    // the network side sees only its own event slot
    assign evt_hit = (addr_a[p][15:4] == NET_CHANGE_TIME_OFS[15:4]) &&
                     (slot == SLOT_NET_CHANGE ||
                      (p == PORT_LOC && (slot == SLOT_LOC_START || slot == SLOT_LOC_CHANGE)));
    assign pd_hit[p] = (addr_a[p] >= PDRAM_BASE) &&
                       (addr_a[p] < PDRAM_BASE + 16'(PDRAM_BYTES));
    assign pr_hit[p] = (addr_a[p] >= PARAM_RAM_BASE) &&
                       (addr_a[p] < PARAM_RAM_BASE + 16'(PARAM_RAM_BYTES));
    assign id_word   = addr_a[p][3] ? VENDOR_IDENTIFICATION : PRODUCT_IDENTIFICATION; // RULE5

    always_comb begin
      rd_byte = 8'h00;
      if (evt_hit) begin
        unique case (addr_a[p][1:0])
          2'h0:    rd_byte = evt_q[slot][7:0];
          2'h1:    rd_byte = hi_q[slot][7:0];   // RULE4
          2'h2:    rd_byte = hi_q[slot][15:8];  // RULE4
          default: rd_byte = hi_q[slot][23:16]; // RULE4
        endcase
      end else if (addr_a[p][15:4] == PRODUCT_IDENTIFICATION_OFS[15:4]) begin
        rd_byte = id_word[8*addr_a[p][2:0] +: 8]; // RULE5 RULE6
      end else if (pr_hit[p]) begin
        rd_byte = pram[PR_AW'(addr_a[p] - PARAM_RAM_BASE)];
      end else if (pd_hit[p] && eeprom_loaded_ok) begin
        rd_byte = pdram[PD_AW'(addr_a[p] - PDRAM_BASE)]; // RULE8 RULE11
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hi_q[0] <= 24'h00_0000;
        hi_q[1] <= 24'h00_0000;
        hi_q[2] <= 24'h00_0000;
        hi_q[3] <= 24'h00_0000;
      end else if (rd_a[p] && evt_hit && addr_a[p][1:0] == 2'h0) begin
        hi_q[slot] <= evt_q[slot][31:8]; // RULE4
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rdata_q[p]  <= 8'h00;
        rvalid_q[p] <= 1'b0;
      end else begin
        rvalid_q[p] <= rd_a[p];
        if (rd_a[p]) begin
          rdata_q[p] <= rd_byte;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_net_evt_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    buffer_manager_net_event |=> evt_q[SLOT_NET_CHANGE] == $past(frame_time_now))
    else $error("network event time not the frame start time");

  a_loc_evt_pair: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    buffer_manager_loc_start |=> (evt_q[SLOT_LOC_START] == $past(local_time)) &&
                                 (evt_q[SLOT_LOC_CHANGE] == $past(local_time)))
    else $error("local event times not captured");

  a_loc_evt_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    !buffer_manager_loc_start |=> $stable(evt_q[SLOT_LOC_CHANGE]))
    else $error("local change time moved without event");

  a_net_evt_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    !buffer_manager_net_event |=> $stable(evt_q[SLOT_NET_CHANGE]))
    else $error("network event time moved without event");

  a_low_byte_snap: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    loc_rd && loc_addr == LOC_START_TIME_OFS
    ##2 loc_rd && loc_addr == LOC_START_TIME_OFS + 16'h0001
    |=> loc_rdata == $past(evt_q[SLOT_LOC_START][15:8], 3))
    else $error("upper byte not consistent with low byte read");

  a_product_read: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    net_rd && net_addr == PRODUCT_IDENTIFICATION_OFS |=> net_rvalid && net_rdata == PRODUCT_IDENTIFICATION[7:0])
    else $error("product_identification low byte wrong");

  a_vendor_dept: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    net_rd && net_addr == VENDOR_IDENTIFICATION_OFS + 16'h0003 |=> net_rdata == DEPT_CODE)
    else $error("vendor department byte wrong");

  a_pdram_blocked: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    net_rd && net_addr >= PDRAM_BASE && net_addr <= PDRAM_LAST && !eeprom_loaded_ok
    |=> net_rdata == 8'h00)
    else $error("process ram readable before eeprom load");

  a_pdram_roundtrip: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    net_wr && net_addr == PDRAM_BASE && eeprom_loaded_ok && !(loc_wr && loc_addr == PDRAM_BASE)
    ##1 !net_wr && !loc_wr
    ##1 loc_rd && loc_addr == PDRAM_BASE && eeprom_loaded_ok
    |=> loc_rdata == $past(net_wdata, 3))
    else $error("process ram write not read back");

  a_param_load: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    load_wr && load_offset < 16'(PARAM_RAM_BYTES)
    |=> pram[PR_AW'($past(load_offset))] == $past(load_data))
    else $error("loader byte not in parameter ram");

  a_param_net_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    net_wr && pr_hit[PORT_NET] && !load_wr && !(loc_wr && loc_addr == net_addr)
    |=> pram[PR_AW'($past(net_addr) - PARAM_RAM_BASE)] == $past(net_wdata))
    else $error("network write not in parameter ram");

  a_param_loc_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    loc_wr && pr_hit[PORT_LOC] && !load_wr
    |=> pram[PR_AW'($past(loc_addr) - PARAM_RAM_BASE)] == $past(loc_wdata))
    else $error("local write not in parameter ram");

  a_vendor_test_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    vendor_is_test == (DEPT_CODE[7:4] == VENDOR_TEST_NIBBLE))
    else $error("test vendor flag wrong");

  a_net_hides_loc: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    net_rd && net_addr == LOC_START_TIME_OFS |=> net_rdata == 8'h00)
    else $error("local event time visible on network side");

endmodule

`default_nettype wire

// >>> sevt_loader_model.sv
// startup eeprom loader model: writes configuration bytes, then reports load status
// assumes clk and rst_b are the bank's own; go lets the bench hold the status low
`timescale 1ns/1ns
`default_nettype none
module sevt_loader_model #(
  parameter int N = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        go,
  output logic             load_wr,
  output logic      [15:0] load_offset,
  output logic      [7:0]  load_data,
  output logic             eeprom_loaded_ok
);
  logic [4:0] cnt_q;
  // waits three edges after reset so the bank's own reset copy has ended
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q            <= '0;
      load_wr          <= 1'b0;
      load_offset      <= '0;
      load_data        <= '0;
      eeprom_loaded_ok <= 1'b0;
    end else begin
      if (cnt_q != 5'(N + 3)) cnt_q <= cnt_q + 5'h1;
      load_wr          <= cnt_q >= 5'h3 && cnt_q < 5'(N + 3);
      load_offset      <= 16'(cnt_q - 5'h3);
      load_data        <= 8'h5a ^ 8'(cnt_q - 5'h3);
      eeprom_loaded_ok <= go && cnt_q == 5'(N + 3);
    end
  end
endmodule
`default_nettype wire

// >>> slave_event_time_id_and_pdram_test.sv
// self-checking bench of the event-time/id/process-ram bank, both ports
// assumes sevt_pkg, sevt_bank and sevt_loader_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module slave_event_time_id_and_pdram_test;
  import sevt_pkg::*;
  localparam logic [63:0] PID = 64'h0123_4567_89ab_cdef; // arbitrary value
  localparam logic [23:0] CMP = 24'h00a5c3;              // arbitrary value
  localparam logic [7:0]  DPT = 8'he3;                   // arbitrary value
  localparam logic [63:0] VID = {32'h0, DPT, CMP};
  logic clk = 0, rst_b = 0, go = 0, frame_start = 0;
  logic buffer_manager_net_event = 0, buffer_manager_loc_start = 0;
  logic [15:0] net_addr = '0, loc_addr = '0, load_offset;
  logic net_rd = 0, net_wr = 0, loc_rd = 0, loc_wr = 0;
  logic [7:0] net_wdata = '0, loc_wdata = '0, net_rdata, loc_rdata, load_data, d;
  logic net_rvalid, loc_rvalid, vendor_is_test, load_wr, eeprom_loaded_ok;
  logic [31:0] local_time = '0, t1, t2, t3;
  logic [7:0] nq[$], lq[$];
  int error_cnt = 0, checked = 0, seed = 32'hdff4;
  always #50 clk = ~clk;
  sevt_bank #(.PRODUCT_IDENTIFICATION(PID), .COMPANY_CODE(CMP), .DEPT_CODE(DPT), .PDRAM_BYTES(64))
    sevt_bank_inst (.clk, .rst_b, .net_addr, .net_rd, .net_wr, .net_wdata, .net_rdata,
    .net_rvalid, .loc_addr, .loc_rd, .loc_wr, .loc_wdata, .loc_rdata, .loc_rvalid,
    .local_time, .frame_start, .buffer_manager_net_event, .buffer_manager_loc_start,
    .eeprom_loaded_ok, .load_wr, .load_offset, .load_data, .vendor_is_test);
  sevt_loader_model sevt_loader_model_inst (.clk, .rst_b, .go, .load_wr, .load_offset,
    .load_data, .eeprom_loaded_ok);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // w=0 reads and notes d as the expected byte
  task automatic acc(input bit p, input bit w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    if (p) begin
      loc_addr <= a; loc_rd <= !w; loc_wr <= w; loc_wdata <= d;
    end else begin
      net_addr <= a; net_rd <= !w; net_wr <= w; net_wdata <= d;
    end
    if (!w && p) lq.push_back(d);
    if (!w && !p) nq.push_back(d);
    @(posedge clk);
    if (p) begin
      loc_rd <= 0; loc_wr <= 0;
    end else begin
      net_rd <= 0; net_wr <= 0;
    end
  endtask
  task automatic r32(input bit p, input logic [15:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) acc(p, 0, a + 16'(i), v[8*i+:8]);
  endtask
  task automatic ev_net(input logic [31:0] t, input bit e);
    @(posedge clk);
    local_time <= t; frame_start <= 1;
    @(posedge clk);
    frame_start <= 0; local_time <= ~t; buffer_manager_net_event <= e;
    @(posedge clk);
    buffer_manager_net_event <= 0;
  endtask
  task automatic ev_loc(input logic [31:0] t);
    @(posedge clk);
    local_time <= t; buffer_manager_loc_start <= 1;
    @(posedge clk);
    buffer_manager_loc_start <= 0; local_time <= ~t;
  endtask
  always @(posedge clk) begin
    if (net_rvalid === 1'b1) begin
      if (nq.size() > 0) chk("net_rdata", net_rdata, nq.pop_front());
      else chk("net_rvalid", 8'h1, 8'h0);
    end
    if (loc_rvalid === 1'b1) begin
      if (lq.size() > 0) chk("loc_rdata", loc_rdata, lq.pop_front());
      else chk("loc_rvalid", 8'h1, 8'h0);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    r32(0, NET_CHANGE_TIME_OFS, 32'h0);
    r32(1, LOC_START_TIME_OFS, 32'h0);
    r32(1, LOC_CHANGE_TIME_OFS, 32'h0);
    acc(1, 1, PDRAM_BASE, 8'h3c);
    acc(0, 1, PDRAM_BASE + 16'h1, 8'hc3);
    acc(1, 0, PDRAM_BASE, 8'h0);
    acc(0, 0, PDRAM_BASE + 16'h1, 8'h0);
    for (int i = 0; i < 8; i++) acc(i[0], 0, PARAM_RAM_BASE + 16'(i), 8'h5a ^ 8'(i));
    d = 8'($random(seed));
    acc(0, 1, PARAM_RAM_BASE + 16'h10, d);
    acc(1, 0, PARAM_RAM_BASE + 16'h10, d);
    d = 8'($random(seed));
    acc(1, 1, PARAM_RAM_BASE + 16'h7f, d);
    acc(0, 0, PARAM_RAM_BASE + 16'h7f, d);
    go <= 1;
    for (int i = 0; i < 50 && eeprom_loaded_ok !== 1'b1; i++) @(posedge clk);
    if (eeprom_loaded_ok !== 1'b1) error_cnt++;
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      acc(i[0], 1, PDRAM_BASE + 16'(i * 17), d);
      acc(!i[0], 0, PDRAM_BASE + 16'(i * 17), d);
    end
    for (int i = 0; i < 8; i++) begin
      acc(i[0], 0, PRODUCT_IDENTIFICATION_OFS + 16'(i), PID[8*i+:8]);
      acc(!i[0], 0, VENDOR_IDENTIFICATION_OFS + 16'(i), VID[8*i+:8]);
    end
    chk("vendor_is_test", {7'h0, vendor_is_test}, {7'h0, VID[31:28] == 4'he});
    t1 = $random(seed);
    t2 = $random(seed);
    t3 = $random(seed);
    ev_net(t1, 1);
    ev_net(t2, 0);
    r32(0, NET_CHANGE_TIME_OFS, t1);
    r32(1, NET_CHANGE_TIME_OFS, t1);
    ev_loc(t2);
    r32(1, LOC_START_TIME_OFS, t2);
    r32(1, LOC_CHANGE_TIME_OFS, t2);
    acc(0, 0, LOC_START_TIME_OFS, 8'h0);
    acc(0, 0, LOC_CHANGE_TIME_OFS + 16'h3, 8'h0);
    acc(1, 0, LOC_START_TIME_OFS, t2[7:0]);
    ev_loc(t3);
    for (int i = 1; i < 4; i++) acc(1, 0, LOC_START_TIME_OFS + 16'(i), t2[8*i+:8]);
    acc(0, 0, NET_CHANGE_TIME_OFS, t1[7:0]);
    ev_net(t3, 1);
    r32(1, NET_CHANGE_TIME_OFS, t3);
    for (int i = 1; i < 4; i++) acc(0, 0, NET_CHANGE_TIME_OFS + 16'(i), t1[8*i+:8]);
    for (int i = 0; i < 50 && nq.size() + lq.size() > 0; i++) @(posedge clk);
    if (nq.size() + lq.size() > 0) error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
